//--- hdl/asr_pkg.sv
/*
  Constants for the host controller of a 4K x 4 asynchronous static memory
  with separate data input and output pins.
  Assumes a 10 MHz system clock; all device times are in nanoseconds.
*/
package asr_pkg;
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 4;
  localparam int WORD_COUNT = 4096;
  localparam int CLK_PERIOD_NS = 100;
  // Device timing for the 10 ns grade
  localparam int READ_CYCLE_TIME_NS = 10;
  localparam int ADDRESS_ACCESS_TIME_NS = 10;
  localparam int SELECT_ACCESS_TIME_NS = 9;
  localparam int OUTPUT_HOLD_TIME_NS = 3;
  localparam int DESELECT_TO_FLOAT_TIME_NS = 5;
  localparam int ADDRESS_TO_WRITE_END_TIME_NS = 9;
  localparam int SELECT_TO_WRITE_END_TIME_NS = 9;
  localparam int STROBE_TO_OUTPUT_VALID_TIME_NS = 12;
  localparam int STROBE_TO_FLOAT_TIME_NS = 5;
  localparam int INPUT_TO_OUTPUT_VALID_TIME_NS = 12;
  localparam int STROBE_RELEASE_TO_DRIVE_TIME_NS = 2;
  localparam int RETENTION_RECOVERY_TIME_NS = READ_CYCLE_TIME_NS;
  // Least times round up, at least one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles
  // Read sample waits for the slower of select and address access
  localparam int READ_WAIT_CYCLES =
    min_cycles((SELECT_ACCESS_TIME_NS > ADDRESS_ACCESS_TIME_NS) ?
               SELECT_ACCESS_TIME_NS : ADDRESS_ACCESS_TIME_NS);
  localparam int WRITE_LOW_CYCLES =
    min_cycles((SELECT_TO_WRITE_END_TIME_NS > ADDRESS_TO_WRITE_END_TIME_NS)
               ? SELECT_TO_WRITE_END_TIME_NS : ADDRESS_TO_WRITE_END_TIME_NS);
  localparam int DESELECT_CYCLES = min_cycles(DESELECT_TO_FLOAT_TIME_NS);
  localparam int RECOVERY_CYCLES = min_cycles(RETENTION_RECOVERY_TIME_NS);
  localparam int CNT_WIDTH = 4;
  localparam logic [CNT_WIDTH-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_WIDTH-1:0] CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    ASR_RECOVER, ASR_IDLE, ASR_READ, ASR_WRITE_SETUP, ASR_WRITE,
    ASR_GAP
  } asr_state_type;
endpackage : asr_pkg

//--- hdl/asr_host.sv
/*
  Host-side controller for a 4K x 4 asynchronous static memory with
  separate data input and output pins. Turns single-cycle read and write
  requests into select / write-strobe sequences on the memory pins.
  Assumes the memory data output returns asynchronously and is sampled
  through two flip-flops; one clock at 10 MHz, async active-low reset.
  Assumes the requester and the retention-exit signal share this clock.
  A request is taken only while ready is shown; others are dropped with
  no indication, and a retention exit wins over a request in the same
  cycle. Select is released between accesses, so every read pays the
  full select access time plus the synchroniser delay. The write strobe
  stays low for one clock, well beyond the least pulse width.
  Outputs are registers with no logic between flop and pin.
*/
// How it works
// - Writes happen only while select and strobe are both low.
// - Select low with strobe high makes the memory drive stored data.
// - Write lasts for the overlap of select low and strobe low.
// - Address is valid no later than select falling on a read.
// - Address held valid 9 ns before write end; zero setup, hold.
// - Select held low at least 9 ns before write end.
// - After data retention, wait one read cycle before accessing.
`timescale 1ns/1ps
module asr_host (
  input  wire logic                            clk_sys_in,
  input  wire logic                            rst_n_in,
  input  wire logic                            req_valid_in,
  input  wire logic                            req_write_in,
  input  wire logic [asr_pkg::ADDR_WIDTH-1:0]  req_addr_in,
  input  wire logic [asr_pkg::DATA_WIDTH-1:0]  req_wdata_in,
  input  wire logic                            retention_exit_in,
  input  wire logic [asr_pkg::DATA_WIDTH-1:0]  mem_dout_in,
  output logic                                 req_ready_out,
  output logic                                 rsp_valid_out,
  output logic [asr_pkg::DATA_WIDTH-1:0]       rsp_rdata_out,
  output logic                                 mem_select_n_out,
  output logic                                 mem_strobe_n_out,
  output logic [asr_pkg::ADDR_WIDTH-1:0]       mem_addr_out,
  output logic [asr_pkg::DATA_WIDTH-1:0]       mem_din_out
);
  import asr_pkg::*;

  asr_state_type              state_r, state_nxt;
  logic [CNT_WIDTH-1:0]       cnt_r, cnt_nxt;
  logic                       ready_r, ready_nxt;
  logic                       rvalid_r, rvalid_nxt;
  logic [DATA_WIDTH-1:0]      rdata_r, rdata_nxt;
  logic                       sel_n_r, sel_n_nxt;
  logic                       stb_n_r, stb_n_nxt;
  // 12-bit word address, separate 4-bit data
  logic [ADDR_WIDTH-1:0]      addr_r, addr_nxt;
  logic [DATA_WIDTH-1:0]      din_r, din_nxt;
  logic [DATA_WIDTH-1:0]      dout_meta_r, dout_sync_r;
  logic [DATA_WIDTH-1:0]      dout_meta_nxt, dout_sync_nxt;
  logic                       take;

  // True once the shared wait counter has run out
  function automatic logic count_done(input logic [CNT_WIDTH-1:0] cnt);
    return cnt == CNT_ZERO;
  endfunction : count_done

  // Memory output is asynchronous to this clock
  always_comb begin
    dout_meta_nxt = mem_dout_in;
    dout_sync_nxt = dout_meta_r;
  end

  // Synchroniser registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dout_meta_r <= '0;
      dout_sync_r <= '0;
    end else begin
      dout_meta_r <= dout_meta_nxt;
      dout_sync_r <= dout_sync_nxt;
    end
  end

  // recovery wins over a request in the same cycle
  always_comb begin
    take = ready_r && req_valid_in && !retention_exit_in;
  end

  // Access sequencer: next pin and handshake values
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    ready_nxt  = 1'b0;
    rvalid_nxt = 1'b0;
    rdata_nxt  = rdata_r;
    sel_n_nxt  = sel_n_r;
    stb_n_nxt  = stb_n_r;
    addr_nxt   = addr_r;
    din_nxt    = din_r;
    if (!count_done(cnt_r)) begin
      cnt_nxt = cnt_r - CNT_ONE;
    end
    case (state_r)
      ASR_RECOVER: begin
        sel_n_nxt = 1'b1;
        stb_n_nxt = 1'b1;
        if (count_done(cnt_r)) begin
          state_nxt = ASR_IDLE;
          ready_nxt = 1'b1;
        end
      end
      ASR_IDLE: begin
        // Ready shown whenever the sequencer idles
        ready_nxt = 1'b1;
        if (retention_exit_in) begin
          state_nxt = ASR_RECOVER;
          cnt_nxt   = CNT_WIDTH'(RECOVERY_CYCLES - 1);
          ready_nxt = 1'b0;
        end else if (take) begin
          ready_nxt = 1'b0;
          addr_nxt  = req_addr_in;
          din_nxt   = req_wdata_in;
          if (req_write_in) begin
            state_nxt = ASR_WRITE_SETUP;
            sel_n_nxt = 1'b0;
          end else begin
            state_nxt = ASR_READ;
            sel_n_nxt = 1'b0;
            stb_n_nxt = 1'b1;
            cnt_nxt   = CNT_WIDTH'(READ_WAIT_CYCLES + 1);
          end
        end
      end
      ASR_READ: begin
        if (count_done(cnt_r)) begin
          rvalid_nxt = 1'b1;
          rdata_nxt  = dout_sync_r;
          sel_n_nxt  = 1'b1;
          state_nxt  = ASR_GAP;
          cnt_nxt    = CNT_WIDTH'(DESELECT_CYCLES - 1);
        end
      end
      ASR_WRITE_SETUP: begin
        stb_n_nxt = 1'b0;
        state_nxt = ASR_WRITE;
        cnt_nxt   = CNT_WIDTH'(WRITE_LOW_CYCLES - 1);
      end
      ASR_WRITE: begin
        if (count_done(cnt_r)) begin
          // both rise together to end the write
          stb_n_nxt = 1'b1;
          sel_n_nxt = 1'b1;
          state_nxt = ASR_GAP;
          cnt_nxt   = CNT_WIDTH'(DESELECT_CYCLES - 1);
        end
      end
      ASR_GAP: begin
        // let outputs float before next access
        if (count_done(cnt_r)) begin
          state_nxt = ASR_IDLE;
          ready_nxt = 1'b1;
        end
      end
      // Unused codes fall back to standby
      default: begin
        state_nxt = ASR_IDLE;
        sel_n_nxt = 1'b1;
        stb_n_nxt = 1'b1;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r  <= ASR_RECOVER;
      cnt_r    <= '0;
      ready_r  <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      sel_n_r  <= 1'b1;
      stb_n_r  <= 1'b1;
      addr_r   <= '0;
      din_r    <= '0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      ready_r  <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      sel_n_r  <= sel_n_nxt;
      stb_n_r  <= stb_n_nxt;
      addr_r   <= addr_nxt;
      din_r    <= din_nxt;
    end
  end

  // Every output comes straight from a register
  assign req_ready_out    = ready_r;
  assign rsp_valid_out    = rvalid_r;
  assign rsp_rdata_out    = rdata_r;
  assign mem_select_n_out = sel_n_r;
  assign mem_strobe_n_out = stb_n_r;
  assign mem_addr_out     = addr_r;
  assign mem_din_out      = din_r;
endmodule : asr_host

//--- test/asr_host_properties.sv
/* Pin checker for asr_host, bound below; one clock, async low reset. */
`timescale 1ns/1ps
module asr_host_properties
  import asr_pkg::*;
(
  input wire logic                  clk_sys_in,
  input wire logic                  rst_n_in,
  input wire logic                  req_valid_in,
  input wire logic                  req_write_in,
  input wire logic [ADDR_WIDTH-1:0] req_addr_in,
  input wire logic                  retention_exit_in,
  input wire logic                  req_ready_out,
  input wire logic                  rsp_valid_out,
  input wire logic                  mem_select_n_out,
  input wire logic                  mem_strobe_n_out,
  input wire logic [ADDR_WIDTH-1:0] mem_addr_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  wire take = req_valid_in && req_ready_out && !retention_exit_in;
  sequence s_write;
    !mem_select_n_out && mem_strobe_n_out ##1 !mem_strobe_n_out ##1
      mem_select_n_out && mem_strobe_n_out;
  endsequence
  property p_strobe; !mem_strobe_n_out |-> !mem_select_n_out; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe unselected");
  property p_write; take && req_write_in |=> s_write; endproperty
  a_write: assert property (p_write) else $error("bad write pulse");
  property p_read; take && !req_write_in |=> !mem_select_n_out &&
    mem_strobe_n_out && mem_addr_out == $past(req_addr_in); endproperty
  a_read: assert property (p_read) else $error("bad read start");
  property p_answer; take && !req_write_in |-> ##[4:5] rsp_valid_out;
  endproperty
  a_answer: assert property (p_answer) else $error("no read answer");
  property p_hold; !mem_select_n_out && !$past(mem_select_n_out) |->
    $stable(mem_addr_out); endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_end; $rose(mem_strobe_n_out) |->
    !$past(mem_select_n_out, 2); endproperty
  a_end: assert property (p_end) else $error("select too short");
  property p_free; rsp_valid_out |-> mem_select_n_out; endproperty
  a_free: assert property (p_free) else $error("still selected");
  property p_recover; retention_exit_in && req_ready_out |=> !req_ready_out
    && mem_select_n_out ##[1:2] req_ready_out; endproperty
  a_recover: assert property (p_recover) else $error("bad recovery");
endmodule : asr_host_properties
bind asr_host asr_host_properties asr_host_properties_i (.clk_sys_in,
  .rst_n_in, .req_valid_in, .req_write_in, .req_addr_in, .retention_exit_in,
  .req_ready_out, .rsp_valid_out, .mem_select_n_out, .mem_strobe_n_out,
  .mem_addr_out);

//--- test/asr_mem_model.sv
/*
  Behavioural 4K x 4 memory standing on the host's pins, with a choice of
  output tracking or floating during writes.
  Assumes select, strobe, address and data come from registers; a floating
  output is shown as the inverse of the last word driven.
*/
`timescale 1ns/1ps
module asr_mem_model
  import asr_pkg::*;
#(parameter int ACCESS_NS = ADDRESS_ACCESS_TIME_NS,
  parameter bit TRACKING  = 1'b1)
(
  input  wire logic                  select_n_in,
  input  wire logic                  strobe_n_in,
  input  wire logic [ADDR_WIDTH-1:0] addr_in,
  input  wire logic [DATA_WIDTH-1:0] din_in,
  output logic      [DATA_WIDTH-1:0] dout_out = 4'h0
);
  logic [DATA_WIDTH-1:0] mem_r [WORD_COUNT];
  logic [DATA_WIDTH-1:0] last_word = 4'h0;
  always @(select_n_in, strobe_n_in, addr_in, din_in) begin
    // write is the overlap of both lows
    if (!select_n_in && !strobe_n_in)
      mem_r[addr_in] = din_in;
    if (select_n_in) begin
      dout_out <= #(DESELECT_TO_FLOAT_TIME_NS) ~last_word;
    end else if (!strobe_n_in && !TRACKING) begin
      dout_out <= #(STROBE_TO_FLOAT_TIME_NS) ~last_word;
    end else if (!strobe_n_in) begin
      // tracking write shows the input word
      last_word = din_in;
      dout_out <= #(INPUT_TO_OUTPUT_VALID_TIME_NS) din_in;
    end else begin
      // old word held, unsettled, then new word
      last_word = mem_r[addr_in];
      dout_out <= #(OUTPUT_HOLD_TIME_NS) 'x;
      dout_out <= #(ACCESS_NS) mem_r[addr_in];
    end
  end
endmodule : asr_mem_model

//--- test/tb_asr_host.sv
/* Bench for asr_host with a tracking memory model; checker bound in. */
`timescale 1ns/1ps
module tb_asr_host;
  import asr_pkg::*;
  logic        clk_sys_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0;
  logic        req_write_in = 1'b0, retention_exit_in = 1'b0;
  logic        req_ready_out, rsp_valid_out, mem_select_n_out;
  logic        mem_strobe_n_out;
  logic [11:0] req_addr_in = 12'h000, mem_addr_out;
  logic [11:0] addr_tab [4] = '{12'h000, 12'hfff, 12'h5a5, 12'h001};
  logic [3:0]  req_wdata_in = 4'h0, mem_dout_in, rsp_rdata_out, mem_din_out;
  int          bad_count = 0, samples_checked = 0;
  asr_host asr_host_i (.clk_sys_in, .rst_n_in, .req_valid_in, .req_write_in,
    .req_addr_in, .req_wdata_in, .retention_exit_in, .mem_dout_in,
    .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .mem_select_n_out,
    .mem_strobe_n_out, .mem_addr_out, .mem_din_out);
  asr_mem_model #(.ACCESS_NS(ADDRESS_ACCESS_TIME_NS), .TRACKING(1'b1))
    asr_mem_model_i (
    .select_n_in(mem_select_n_out), .strobe_n_in(mem_strobe_n_out),
    .addr_in(mem_addr_out), .din_in(mem_din_out), .dout_out(mem_dout_in));
  initial forever #50 clk_sys_in = ~clk_sys_in;
  task automatic check(input logic [11:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic give_up(input int n);
    if (n < 20)
      return;
    bad_count++;
    complete_run();
  endtask : give_up
  // Holds the request until taken; a read also waits for its answer
  task automatic access(input bit wr, input logic [11:0] a, input int d);
    int n;
    @(posedge clk_sys_in);
    {req_valid_in, req_write_in, req_addr_in} <= {1'b1, wr, a};
    req_wdata_in <= d[3:0];
    @(negedge clk_sys_in);
    for (n = 0; n < 20 && req_ready_out !== 1'b1; n++) @(negedge clk_sys_in);
    give_up(n);
    @(posedge clk_sys_in);
    req_valid_in <= 1'b0;
    for (n = 0; !wr && n < 20 && rsp_valid_out !== 1'b1; n++)
      @(negedge clk_sys_in);
    give_up(n);
  endtask : access
  task automatic t_write_read;
    for (int i = 0; i < 4; i++) begin
      access(1'b1, addr_tab[i], 3 * i + 3);
      @(negedge clk_sys_in);
      check(mem_addr_out, addr_tab[i]);
      check(12'(mem_din_out), 12'(3 * i + 3));
      check({10'h000, mem_select_n_out, mem_strobe_n_out}, 12'h001);
      @(negedge clk_sys_in);
      check({10'h000, mem_select_n_out, mem_strobe_n_out}, 12'h000);
    end
    for (int i = 3; i >= 0; i--) begin
      access(1'b0, addr_tab[i], 0);
      check(12'(rsp_rdata_out), 12'(3 * i + 3));
      check(mem_addr_out, addr_tab[i]);
      check({10'h000, mem_select_n_out, mem_strobe_n_out}, 12'h003);
    end
  endtask : t_write_read
  // Request beside a recovery pulse must be dropped
  task automatic t_retention;
    @(posedge clk_sys_in);
    {retention_exit_in, req_valid_in} <= 2'b11;
    @(posedge clk_sys_in);
    {retention_exit_in, req_valid_in} <= 2'b00;
    @(negedge clk_sys_in);
    check({11'h000, mem_select_n_out}, 12'h001);
    check({11'h000, req_ready_out}, 12'h000);
    access(1'b0, 12'h000, 0);
    check(12'(rsp_rdata_out), 12'h003);
  endtask : t_retention
  // Mid-run reset: pins back to standby, stored words survive
  task automatic t_reset;
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    @(negedge clk_sys_in);
    check({11'h000, mem_select_n_out}, 12'h001);
    check({10'h000, rsp_valid_out, req_ready_out}, 12'h000);
    check(12'(rsp_rdata_out), 12'h000);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(negedge clk_sys_in);
    check({11'h000, req_ready_out}, 12'h000);
    access(1'b0, addr_tab[2], 0);
    check(12'(rsp_rdata_out), 12'h009);
  endtask : t_reset
  initial begin
    repeat (8) @(posedge clk_sys_in);
    check({10'h000, mem_select_n_out, mem_strobe_n_out}, 12'h003);
    rst_n_in <= 1'b1;
    t_write_read();
    t_retention();
    t_reset();
    complete_run();
  end
endmodule : tb_asr_host
